/* File: hw/fcdc_top.sv */
`timescale 1ns/100ps
`include "fcdc_defs.svh"

module fcdc_top
	import fcdc_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic             pslverr,
	output logic [31:0]      prdata,
	input  wire logic        special_mode,
	input  wire logic        rd_valid,
	input  wire logic [22:0] rd_addr,
	output logic             rd_invalid,
	output logic             op_start,
	output fcdc_op_t         op,
	input  wire logic        op_done,
	input  wire logic        op_err_any,
	input  wire logic        op_err_ncorr,
	output logic             command_complete_flag
);
	localparam int NPARAM = 6;

	fcdc_state_t state;
	fcdc_state_t next_state;
	logic [7:0]  flash_clock_divider_reg;
	logic        div_init;
	logic [3:0]  pflash_protection_reg;
	logic [2:0]  param_index;
	logic [15:0] command_param_reg [NPARAM];
	logic        access_error_flag;
	logic        protection_violation_flag;
	logic        margin_status_hi;
	logic        margin_status_lo;
	logic        single_fault_flag;
	logic        double_fault_flag;
	logic [22:0] fault_addr;
	logic        special_q1;
	logic        special_q2;

	// APB decode; a write acts at the edge that samples pready high
	wire acc      = psel & penable & pready;
	wire wr       = acc & pwrite;
	wire sel_div  = paddr == `FCDC_CLKDIV_OFS;
	wire sel_stat = paddr == `FCDC_STAT_OFS;
	wire sel_prot = paddr == `FCDC_PROT_OFS;
	wire sel_idx  = paddr == `FCDC_IDX_OFS;
	wire sel_par  = paddr == `FCDC_PARAM_OFS;
	wire sel_flt  = paddr == `FCDC_FAULT_OFS;
	wire sel_fadr = paddr == `FCDC_FADDR_OFS;
	wire sel_fdat = paddr == `FCDC_FDATA_OFS;
	wire mapped   = sel_div | sel_stat
		| sel_prot | sel_idx
		| sel_par | sel_flt
		| sel_fadr | sel_fdat;
	wire idx_ok   = param_index < 3'(NPARAM);

	wire [7:0]  cmd = command_param_reg[0][15:8];
	wire [6:0]  blk = command_param_reg[0][6:0];
	wire [22:0] cmd_addr = {blk, command_param_reg[1]};

	wire code_ok = cmd == `FCDC_CMD_EVALL
		|| cmd == `FCDC_CMD_EVBLK
		|| cmd == `FCDC_CMD_ERALL
		|| cmd == `FCDC_CMD_ERBLK
		|| cmd == `FCDC_CMD_UNSEC
		|| cmd == `FCDC_CMD_UMARG
		|| cmd == `FCDC_CMD_FMARG
		|| cmd == `FCDC_CMD_EVSEC
		|| cmd == `FCDC_CMD_PROG
		|| cmd == `FCDC_CMD_ERSEC;
	wire prog_erase = cmd == `FCDC_CMD_ERALL
		|| cmd == `FCDC_CMD_ERBLK
		|| cmd == `FCDC_CMD_UNSEC
		|| cmd == `FCDC_CMD_PROG
		|| cmd == `FCDC_CMD_ERSEC;
	// Codes that report margin status
	wire is_verify = cmd == `FCDC_CMD_EVALL
		|| cmd == `FCDC_CMD_EVBLK
		|| cmd == `FCDC_CMD_EVSEC
		|| cmd == `FCDC_CMD_UNSEC;

	wire acc_code = ~code_ok;
	wire acc_div  = prog_erase & ~div_init;
	wire acc_idx  = cmd == `FCDC_CMD_EVALL & param_index != 3'h0;
	wire acc_mode = cmd == `FCDC_CMD_FMARG & ~special_q2;
	wire chk_acc  = acc_code | acc_div | acc_idx | acc_mode;

	wire pf_all = pflash_protection_reg[`FCDC_PROT_PLDIS]
		& pflash_protection_reg[`FCDC_PROT_PHDIS]
		& pflash_protection_reg[`FCDC_PROT_POPEN];
	wire dflash_open = pflash_protection_reg[`FCDC_PROT_DOPEN];
	wire is_dblk = blk == `FCDC_DFLASH_BLK;

	wire viol_all = cmd == `FCDC_CMD_ERALL & ~(pf_all & dflash_open);
	// open bits of the chosen block
	wire viol_blk = cmd == `FCDC_CMD_ERBLK
		& (is_dblk ? ~dflash_open : ~pf_all);
	// Access error outranks violation
	wire chk_viol = ~chk_acc & (viol_all | viol_blk);

	// launch by clearing the complete flag
	wire launch = wr & sel_stat & pwdata[`FCDC_STAT_COMMAND_COMPLETE_FLAG]
		& state == FCDC_IDLE & ~access_error_flag
		& ~protection_violation_flag;
	// a failed check never leaves idle
	wire go = launch & ~chk_acc & ~chk_viol;
	wire done = state == FCDC_BUSY & op_done;

	// Operations that span every block
	wire op_all = op.code == `FCDC_CMD_EVALL
		|| op.code == `FCDC_CMD_ERALL
		|| op.code == `FCDC_CMD_UNSEC;
	wire collide = rd_valid & ~command_complete_flag
		& (op_all || rd_addr[22:16] == op.addr[22:16]);
	// capture only when no fault pending
	wire fault_cap = collide & ~single_fault_flag & ~double_fault_flag;

	wire clr_stat = wr & sel_stat;
	wire clr_flt  = wr & sel_flt;

	always_comb begin
		next_state = state;
		unique case (state)
			FCDC_IDLE: begin
				if (go)
					next_state = FCDC_START;
			end
			FCDC_START: begin
				next_state = FCDC_BUSY;
			end
			FCDC_BUSY: begin
				if (op_done)
					next_state = FCDC_IDLE;
			end
			default: begin
				next_state = FCDC_IDLE;
			end
		endcase
	end

	// Flags: hardware set wins over write-one-to-clear
	// access error
	wire next_access_error_flag = (launch & chk_acc) | (access_error_flag
		& ~(clr_stat & pwdata[`FCDC_STAT_ACCESS_ERROR_FLAG]));
	wire next_protection_violation_flag = (launch & chk_viol) | (protection_violation_flag
		& ~(clr_stat & pwdata[`FCDC_STAT_PROTECTION_VIOLATION_FLAG]));
	wire next_sgl = fault_cap | (single_fault_flag
		& ~(clr_flt & pwdata[`FCDC_FAULT_SGL]));
	wire next_dbl = fault_cap | (double_fault_flag
		& ~(clr_flt & pwdata[`FCDC_FAULT_DBL]));

	// Margin status from the verify reads
	wire vfy_done = done & is_verify;
	wire next_mg_hi = go ? 1'b0
		: (vfy_done ? op_err_any : margin_status_hi);
	wire next_mg_lo = go ? 1'b0
		: (vfy_done ? op_err_ncorr : margin_status_lo);

	// Status byte as software reads it
	wire [7:0] stat_rd = {
		command_complete_flag,
		1'b0,
		access_error_flag,
		protection_violation_flag,
		2'b00,
		margin_status_hi,
		margin_status_lo
	};

	wire [31:0] rdata =
		sel_div  ? {24'h0, flash_clock_divider_reg} :
		sel_stat ? {24'h0, stat_rd} :
		sel_prot ? {28'h0, pflash_protection_reg} :
		sel_idx  ? {29'h0, param_index} :
		sel_par  ? (idx_ok ? {16'h0, command_param_reg[param_index]}
			: 32'h0) :
		sel_flt  ? {30'h0, double_fault_flag, single_fault_flag} :
		sel_fadr ? {9'h0, fault_addr} :
		32'h0;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
		end else begin
			// One wait state, reply stands a cycle
			pready  <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & ~mapped;
			prdata  <= (psel & penable & ~pready & ~pwrite) ? rdata : 32'h0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			special_q1 <= 1'b0;
			special_q2 <= 1'b0;
		end else begin
			// Mode pin is asynchronous
			special_q1 <= special_mode;
			special_q2 <= special_q1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			flash_clock_divider_reg <= `FCDC_CLKDIV_RST;
			div_init                <= 1'b0;
			pflash_protection_reg   <= `FCDC_PROT_RST;
			param_index             <= `FCDC_IDX_RST;
		end else begin
			// Any divider write counts as set
			if (wr & sel_div) begin
				flash_clock_divider_reg <= pwdata[7:0];
				div_init                <= 1'b1;
			end
			if (wr & sel_prot)
				pflash_protection_reg <= pwdata[3:0];
			if (wr & sel_idx)
				param_index <= pwdata[2:0];
		end
	end

	// Parameter words, one per index
	for (genvar i = 0; i < NPARAM; i++) begin : g_param
		always_ff @(posedge clk) begin
			if (!rst_n)
				command_param_reg[i] <= 16'h0;
			else if (wr & sel_par & param_index == 3'(i) & state == FCDC_IDLE)
				command_param_reg[i] <= pwdata[15:0];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state                     <= FCDC_IDLE;
			command_complete_flag     <= 1'b1;
			access_error_flag         <= 1'b0;
			protection_violation_flag <= 1'b0;
			margin_status_hi          <= 1'b0;
			margin_status_lo          <= 1'b0;
		end else begin
			state                     <= next_state;
			command_complete_flag     <= go ? 1'b0
				: (done | command_complete_flag);
			access_error_flag         <= next_access_error_flag;
			protection_violation_flag <= next_protection_violation_flag;
			margin_status_hi          <= next_mg_hi;
			margin_status_lo          <= next_mg_lo;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			op_start <= 1'b0;
			op       <= '0;
		end else begin
			op_start <= go;
			if (go) begin
				op.code  <= cmd;
				op.addr  <= cmd_addr;
				op.count <= command_param_reg[2];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rd_invalid        <= 1'b0;
			single_fault_flag <= 1'b0;
			double_fault_flag <= 1'b0;
			fault_addr        <= 23'h0;
		end else begin
			rd_invalid        <= collide;
			single_fault_flag <= next_sgl;
			double_fault_flag <= next_dbl;
			if (fault_cap)
				fault_addr <= rd_addr;
		end
	end

endmodule : fcdc_top

/* File: hw/fcdc_defs.svh */
`ifndef FCDC_DEFS_SVH
`define FCDC_DEFS_SVH

// Register byte offsets
`define FCDC_CLKDIV_OFS 8'h00
`define FCDC_STAT_OFS   8'h04
`define FCDC_PROT_OFS   8'h08
`define FCDC_IDX_OFS    8'h0c
`define FCDC_PARAM_OFS  8'h10
`define FCDC_FAULT_OFS  8'h14
`define FCDC_FADDR_OFS  8'h18
`define FCDC_FDATA_OFS  8'h1c

// Status fields
`define FCDC_STAT_COMMAND_COMPLETE_FLAG   7
`define FCDC_STAT_ACCESS_ERROR_FLAG 5
`define FCDC_STAT_PROTECTION_VIOLATION_FLAG 4
`define FCDC_STAT_MG_HI  1
`define FCDC_STAT_MG_LO  0

// Protection fields
`define FCDC_PROT_PLDIS 0
`define FCDC_PROT_PHDIS 1
`define FCDC_PROT_POPEN 2
`define FCDC_PROT_DOPEN 3

// Fault fields
`define FCDC_FAULT_SGL 0
`define FCDC_FAULT_DBL 1

// Reset values and D-flash block number
`define FCDC_CLKDIV_RST 8'h00
`define FCDC_PROT_RST   4'h0
`define FCDC_IDX_RST    3'h0
`define FCDC_DFLASH_BLK 7'h10

// Command codes
`define FCDC_CMD_EVALL  8'h01
`define FCDC_CMD_EVBLK  8'h02
`define FCDC_CMD_ERALL  8'h08
`define FCDC_CMD_ERBLK  8'h09
`define FCDC_CMD_UNSEC  8'h0b
`define FCDC_CMD_UMARG  8'h0d
`define FCDC_CMD_FMARG  8'h0e
`define FCDC_CMD_EVSEC  8'h10
`define FCDC_CMD_PROG   8'h11
`define FCDC_CMD_ERSEC  8'h12
`endif

/* File: hw/fcdc_pkg.sv */
package fcdc_pkg;
	typedef enum logic [1:0] {
		FCDC_IDLE  = 2'b00,
		FCDC_START = 2'b01,
		FCDC_BUSY  = 2'b11
	} fcdc_state_t;

	typedef struct packed {
		logic [7:0]  code;
		logic [22:0] addr;
		logic [15:0] count;
	} fcdc_op_t;
endpackage : fcdc_pkg

/* File: bench/fcdc_properties.sv */
`timescale 1ns/100ps
module fcdc_properties
	import fcdc_pkg::*;
(
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [31:0] prdata,
	input wire logic        rd_valid,
	input wire logic [22:0] rd_addr,
	input wire logic        rd_invalid,
	input wire logic        op_start,
	input wire fcdc_op_t    op,
	input wire logic        op_done,
	input wire logic        command_complete_flag
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	chk_one_wait: assert property (psel && penable && !pready |=> pready)
		else $error("access phase not one wait state");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("pready held too long");
	chk_err_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
		else $error("prdata not zero outside reply");
	chk_start_launch: assert property (
		op_start |-> !command_complete_flag && $past(command_complete_flag))
		else $error("op_start without idle launch");
	chk_done_flag: assert property (
		op_done && !command_complete_flag && !op_start
		|=> command_complete_flag)
		else $error("flag not set after op_done");
	chk_fall_start: assert property (
		$fell(command_complete_flag) |-> op_start)
		else $error("flag fell without op_start");
	chk_op_hold: assert property (!command_complete_flag && !op_start
		|-> $stable(op)) else $error("op changed while busy");
	chk_collision: assert property (
		rd_valid && !command_complete_flag && rd_addr[22:16] == op.addr[22:16]
		|=> rd_invalid) else $error("colliding read not flagged");
	chk_no_spurious: assert property (
		rd_invalid |-> $past(rd_valid) && !$past(command_complete_flag))
		else $error("rd_invalid without collision");
endmodule : fcdc_properties

bind fcdc_top fcdc_properties chk_u (.clk(clk), .rst_n(rst_n), .psel(psel),
	.penable(penable), .pready(pready), .pslverr(pslverr), .prdata(prdata),
	.rd_valid(rd_valid), .rd_addr(rd_addr), .rd_invalid(rd_invalid),
	.op_start(op_start), .op(op), .op_done(op_done),
	.command_complete_flag(command_complete_flag));

/* File: bench/fcdc_top_tb_top.sv */
`timescale 1ns/100ps
`include "fcdc_defs.svh"
module fcdc_top_tb_top
	import fcdc_pkg::*;
;
	typedef struct packed {
		logic [7:0] c;
		logic       ok, a, n;
		logic [1:0] mg;
	} fcdc_row_t;
	logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
	logic        special_mode, rd_valid, rd_invalid, op_start, op_done;
	logic        op_err_any, op_err_ncorr, command_complete_flag, s;
	logic [7:0]  paddr, last_code;
	logic [31:0] pwdata, prdata, r;
	logic [22:0] rd_addr;
	fcdc_op_t    op;
	int          failures, n_tests, starts, cyc;
	fcdc_row_t   rows[11] = '{'{8'h01,1,1,0,2'b10}, '{8'h02,1,1,1,2'b11},
		'{8'h10,1,0,0,0}, '{8'h0b,1,0,1,2'b01}, '{8'h08,1,1,1,0},
		'{8'h03,0,0,0,0}, '{8'h09,1,0,0,0}, '{8'h0d,1,0,0,0},
		'{8'h0e,1,0,0,0}, '{8'h11,1,0,0,0}, '{8'h12,1,0,0,0}};

	fcdc_top dut_u (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.pslverr(pslverr), .prdata(prdata), .special_mode(special_mode),
		.rd_valid(rd_valid), .rd_addr(rd_addr), .rd_invalid(rd_invalid),
		.op_start(op_start), .op(op), .op_done(op_done),
		.op_err_any(op_err_any), .op_err_ncorr(op_err_ncorr),
		.command_complete_flag(command_complete_flag));

	initial begin
		clk = 0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (op_start === 1'b1) begin
			starts++;
			last_code = op.code;
		end
		if (cyc == 20000) begin
			failures++;
			final_report;
		end
	end

	task final_report;
		if (failures == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : final_report
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk) penable <= 1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		r = prdata;
		s = pslverr;
		psel <= 0;
		penable <= 0;
	endtask : apb
	task go(input logic [7:0] c, input logic [2:0] ix);
		int k;
		apb(1, `FCDC_IDX_OFS, 0);
		apb(1, `FCDC_PARAM_OFS, {16'h0, c, `FCDC_DFLASH_BLK & 8'h7f});
		apb(1, `FCDC_IDX_OFS, {29'h0, ix});
		k = starts;
		apb(1, `FCDC_STAT_OFS, 32'h80);
		repeat (3) @(posedge clk);
		#1 s = (starts != k);
	endtask : go
	task fin(input logic a, input logic n);
		@(posedge clk);
		op_done <= 1;
		op_err_any <= a;
		op_err_ncorr <= n;
		@(posedge clk) op_done <= 0;
	endtask : fin
	task coll(input logic [22:0] a, input logic e);
		@(posedge clk);
		rd_valid <= 1;
		rd_addr <= a;
		@(posedge clk) rd_valid <= 0;
		#1 chk("rd_invalid", rd_invalid, e);
	endtask : coll

	initial begin
		{psel, penable, pwrite, paddr, pwdata, rd_valid, rd_addr} = 0;
		{op_done, op_err_any, op_err_ncorr, rst_n} = 0;
		special_mode = 1;
		repeat (4) @(posedge clk);
		rst_n <= 1;
		#1 chk("flag_rst", command_complete_flag, 1);
		apb(0, `FCDC_PROT_OFS, 0);
		chk("prot_rst", r, `FCDC_PROT_RST);
		apb(0, 8'h20, 0);
		chk("unmapped_err", s, 1);
		chk("unmapped", r, 0);
		apb(1, `FCDC_PROT_OFS, 32'hf);
		go(8'h11, 0);
		chk("nodiv", s, 0);
		apb(0, `FCDC_STAT_OFS, 0);
		chk("nodiv_st", r[7:4], 4'ha);
		apb(1, `FCDC_STAT_OFS, 32'h30);
		apb(1, `FCDC_CLKDIV_OFS, 32'h0a);
		apb(1, `FCDC_IDX_OFS, 1);
		apb(1, `FCDC_PARAM_OFS, 32'h1234);
		apb(1, `FCDC_IDX_OFS, 2);
		apb(1, `FCDC_PARAM_OFS, 32'h5);
		foreach (rows[i]) begin
			go(rows[i].c, 0);
			chk("start", s, rows[i].ok);
			if (rows[i].ok) begin
				chk("code", last_code, rows[i].c);
				chk("busy", command_complete_flag, 0);
				if (rows[i].c == `FCDC_CMD_EVSEC)
					chk("count", op.count, 16'h0005);
				fin(rows[i].a, rows[i].n);
			end
			apb(0, `FCDC_STAT_OFS, 0);
			chk("stat", {r[7], r[5:4], r[1:0]},
				{2'b11 ^ rows[i].ok, 1'b0, rows[i].mg});
			apb(1, `FCDC_STAT_OFS, 32'h30);
		end
		go(8'h01, 1);
		chk("idx_start", s, 0);
		apb(0, `FCDC_STAT_OFS, 0);
		chk("idx", {s, r[7:4]}, 5'h0a);
		apb(1, `FCDC_STAT_OFS, 32'h30);
		special_mode <= 0;
		go(8'h0e, 0);
		chk("fmarg", s, 0);
		apb(1, `FCDC_STAT_OFS, 32'h30);
		special_mode <= 1;
		apb(1, `FCDC_PROT_OFS, 32'h7);
		go(8'h08, 0);
		chk("prot_start", s, 0);
		apb(0, `FCDC_STAT_OFS, 0);
		chk("prot", {s, r[7], r[5:4]}, 4'b0101);
		apb(1, `FCDC_STAT_OFS, 32'h30);
		go(8'h09, 0);
		chk("blk_start", s, 0);
		apb(0, `FCDC_STAT_OFS, 0);
		chk("blk_viol", r[5:4], 2'b01);
		apb(1, `FCDC_STAT_OFS, 32'h30);
		go(8'h02, 0);
		chk("op_addr", op.addr, {`FCDC_DFLASH_BLK, 16'h1234});
		coll(23'h101234, 1);
		apb(0, `FCDC_FAULT_OFS, 0);
		chk("fault", r, 3);
		coll(23'h105678, 1);
		apb(0, `FCDC_FADDR_OFS, 0);
		chk("faddr", r, 32'h101234);
		coll(23'h010000, 0);
		fin(0, 0);
		apb(0, `FCDC_FDATA_OFS, 0);
		chk("fdata", r, 0);
		final_report;
	end
endmodule : fcdc_top_tb_top
